/* include/pecr_pkg.sv */
// pecr_pkg: constants and types of the extended control and interrupt regs
//
// Behaviour
// - control one bit 12 picks GMII or RGMII
// - new interface mode acts only at soft reset
// - control one bit 8 adds RGMII clock skew
// - control one bit 1 reverses GMII transmit pins
// - control two bits 15:13 set edge rate
// - control two bits 3:1 report cable length
// - control two bit 0 enables connector loopback
// - mask bit 15 lets pin follow summary bit
// - pin enable never stops cause recording
// - mask bits enable causes, reset to zero
// - status bits clear by the read returning them
// - status bit 15 is the summary flag
// - speed and duplex causes need negotiation enable
// - downshift cause needs advertisement bits 8:5
// - sticky bits survive soft reset when enabled
`default_nettype none

package pecr_pkg;

  // management address and data widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [4:0] OFF_CTL1 = 5'h17;
  localparam logic [4:0] OFF_CTL2 = 5'h18;
  localparam logic [4:0] OFF_MASK = 5'h19;
  localparam logic [4:0] OFF_STATUS = 5'h1a;

  // control one field positions
  localparam int unsigned CTL1_MODE_BIT = 12;
  localparam int unsigned CTL1_SKEW_BIT = 8;
  localparam int unsigned CTL1_PWR_BIT = 5;
  localparam int unsigned CTL1_REV_BIT = 1;
  // control two field positions
  localparam int unsigned CTL2_EDGE_LO = 13;
  localparam int unsigned CTL2_CABLE_LO = 1;
  localparam int unsigned CTL2_LOOP_BIT = 0;
  // mask and status field positions
  localparam int unsigned INT_SUM_BIT = 15;
  localparam int unsigned INT_SPEED_BIT = 14;
  localparam int unsigned INT_LINK_BIT = 13;
  localparam int unsigned INT_DUPLEX_BIT = 12;
  localparam int unsigned INT_NEGERR_BIT = 11;
  localparam int unsigned INT_NEGDONE_BIT = 10;
  localparam int unsigned INT_PD_BIT = 9;
  localparam int unsigned INT_DOWN_BIT = 2;
  localparam int unsigned INT_MSERR_BIT = 1;

  // writable bits of control one and mask, then the status cause bits; all others reserved
  localparam logic [15:0] CTL1_WMASK = 16'h1122;
  localparam logic [15:0] MASK_WMASK = 16'hfe06;
  localparam logic [15:0] CAUSE_MASK = 16'h7e06;
  // mask bit that is not sticky
  localparam logic [15:0] MASK_PLAIN = 16'h0800;

  // reset values
  localparam logic [15:0] CTL1_RST = 16'h0000;
  localparam logic [2:0] EDGE_RST = 3'h6;
  localparam logic LOOP_RST = 1'b0;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // strap levels sampled after hardware reset
  typedef struct packed {
    logic mode;
    logic skew;
    logic pwr;
  } pecr_strap_t;

  // one-cycle event pulses from the link logic
  typedef struct packed {
    logic speed;
    logic link;
    logic duplex;
    logic neg_err;
    logic neg_done;
    logic pd_detect;
    logic downshift;
    logic ms_err;
  } pecr_evt_t;

  // settings driven into the datapath and analog
  typedef struct packed {
    logic rgmii;
    logic skew;
    logic pwr;
    logic tx_rev;
    logic [2:0] edge_rate;
    logic loopback;
  } pecr_cfg_t;

  // strap capture, then normal running
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } pecr_state_t;

endpackage : pecr_pkg

`default_nettype wire

/* rtl/pecr_regs.sv */
// pecr_regs: extended control and interrupt mask/status registers
`default_nettype none

module pecr_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [pecr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pecr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pecr_pkg::DATA_W-1:0] reg_rdata,
  input wire pecr_pkg::pecr_strap_t config_strap_pins,
  input wire logic soft_reset,
  input wire logic sticky_reset_en,
  input wire logic aneg_enable,
  input wire logic [3:0] adv_speed_bits,
  input wire logic [2:0] cable_length,
  input wire pecr_pkg::pecr_evt_t events,
  output pecr_pkg::pecr_cfg_t cfg,
  output logic mgmt_interrupt_pin,
  output logic irq
);
  import pecr_pkg::*;

  // true when the address selects the given offset
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [4:0] off
  );
    addr_hit = (addr == off);
  endfunction : addr_hit

  // default control one image built from strap levels
  function automatic logic [15:0] strap_ctl1(
    input pecr_strap_t s
  );
    logic [15:0] v;
    v = CTL1_RST;
    v[CTL1_MODE_BIT] = s.mode;
    v[CTL1_SKEW_BIT] = s.skew;
    v[CTL1_PWR_BIT] = s.pwr;
    strap_ctl1 = v;
  endfunction : strap_ctl1

  // map qualified event pulses onto status bit places
  function automatic logic [15:0] evt_bits(
    input pecr_evt_t e,
    input logic neg_en,
    input logic [3:0] adv
  );
    logic [15:0] v;
    v = 16'h0000;
    // speed and duplex only count with negotiation on
    v[INT_SPEED_BIT] = e.speed & neg_en;
    v[INT_DUPLEX_BIT] = e.duplex & neg_en;
    v[INT_LINK_BIT] = e.link;
    v[INT_NEGERR_BIT] = e.neg_err;
    v[INT_NEGDONE_BIT] = e.neg_done;
    v[INT_PD_BIT] = e.pd_detect;
    // downshift needs every speed advertised
    v[INT_DOWN_BIT] = e.downshift & (&adv);
    v[INT_MSERR_BIT] = e.ms_err;
    evt_bits = v;
  endfunction : evt_bits

  // sequencing state
  pecr_state_t state;
  pecr_state_t next_state;

  // strap levels kept as soft reset defaults
  pecr_strap_t strap;
  pecr_strap_t next_strap;

  // control one image, reserved bits held at zero
  logic [15:0] ctl1;
  logic [15:0] next_ctl1;

  // interface mode actually in force
  logic rgmii_act;
  logic next_rgmii_act;

  // control two writable fields
  logic [2:0] edge_rate;
  logic [2:0] next_edge_rate;
  logic loopback;
  logic next_loopback;

  // interrupt mask and status
  logic [15:0] int_mask;
  logic [15:0] next_int_mask;
  logic [15:0] int_status;
  logic [15:0] next_int_status;

  // read data selected for the next cycle
  logic [15:0] next_rdata;

  // decoded strobes, only while running
  wire run = (state == ST_RUN);
  wire wr_ctl1 = run & reg_wr & addr_hit(reg_addr, OFF_CTL1);
  wire wr_ctl2 = run & reg_wr & addr_hit(reg_addr, OFF_CTL2);
  wire wr_mask = run & reg_wr & addr_hit(reg_addr, OFF_MASK);
  wire rd_status = run & reg_rd & addr_hit(reg_addr, OFF_STATUS);

  // soft reset split by the sticky enable
  wire sr_any = run & soft_reset;
  wire sr_sticky = sr_any & ~sticky_reset_en;

  // qualified causes arriving this cycle
  wire [15:0] cause_set = run ?
    evt_bits(events, aneg_enable, adv_speed_bits) : 16'h0000;

  // bits a status read or soft reset drops
  wire [15:0] status_clr =
    (rd_status | sr_any) ? 16'hffff : 16'h0000;

  // control two read image with live cable length
  wire [15:0] ctl2_view = {edge_rate, 9'h000, cable_length,
    loopback};

  // state sequencing
  always_comb begin
    case (state)
      ST_STRAP: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_STRAP;
      end
    endcase
  end

  // straps are caught once, after reset release
  always_comb begin
    next_strap = strap;
    if (state == ST_STRAP) begin
      next_strap = config_strap_pins;
    end
  end

  // control one update
  always_comb begin
    next_ctl1 = ctl1;
    if (state == ST_STRAP) begin
      // hardware defaults come from the straps
      next_ctl1 = strap_ctl1(config_strap_pins);
    end else begin
      if (sr_sticky) begin
        // mode bit is super-sticky, the rest fall back
        next_ctl1 = (strap_ctl1(strap) & ~CTL1_WMASK) |
          (strap_ctl1(strap) & CTL1_WMASK &
          ~(16'h0001 << CTL1_MODE_BIT)) |
          (ctl1 & (16'h0001 << CTL1_MODE_BIT));
      end
      if (wr_ctl1) begin
        // reserved bits are dropped on write
        next_ctl1 = reg_wdata & CTL1_WMASK;
      end
    end
  end

  // the selected mode takes effect only at soft reset
  always_comb begin
    next_rgmii_act = rgmii_act;
    if (state == ST_STRAP) begin
      next_rgmii_act = config_strap_pins.mode;
    end else if (sr_any) begin
      // a write in the same cycle waits for the next reset
      next_rgmii_act = ctl1[CTL1_MODE_BIT];
    end
  end

  // control two update
  always_comb begin
    next_edge_rate = edge_rate;
    next_loopback = loopback;
    if (sr_sticky) begin
      next_edge_rate = EDGE_RST;
    end
    if (sr_any) begin
      // loopback is not sticky, so any soft reset clears it
      next_loopback = LOOP_RST;
    end
    if (wr_ctl2) begin
      next_edge_rate = reg_wdata[CTL2_EDGE_LO +: 3];
      next_loopback = reg_wdata[CTL2_LOOP_BIT];
    end
  end

  // mask update
  always_comb begin
    next_int_mask = int_mask;
    if (sr_sticky) begin
      next_int_mask = MASK_RST;
    end else if (sr_any) begin
      // the error mask bit is plain and always resets
      next_int_mask = int_mask & ~MASK_PLAIN;
    end
    if (wr_mask) begin
      next_int_mask = reg_wdata & MASK_WMASK;
    end
  end

  // status update, new causes beat the read clear
  always_comb begin
    next_int_status = STATUS_RST;
    // causes record whatever the mask or pin enable
    next_int_status = ((int_status & ~status_clr) | cause_set) &
      CAUSE_MASK;
    // summary mirrors any pending masked cause
    next_int_status[INT_SUM_BIT] =
      |(next_int_status & int_mask & CAUSE_MASK);
  end

  // read multiplexer, unmapped offsets answer zero
  always_comb begin
    next_rdata = 16'h0000;
    if (addr_hit(reg_addr, OFF_CTL1)) begin
      next_rdata = ctl1;
    end else if (addr_hit(reg_addr, OFF_CTL2)) begin
      next_rdata = ctl2_view;
    end else if (addr_hit(reg_addr, OFF_MASK)) begin
      next_rdata = int_mask;
    end else if (addr_hit(reg_addr, OFF_STATUS)) begin
      // returns the bits this very read then clears
      next_rdata = int_status;
    end
  end

  // sequencing and strap flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STRAP;
      strap <= '0;
    end else if (clk_en) begin
      state <= next_state;
      strap <= next_strap;
    end
  end

  // control flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1 <= CTL1_RST;
      rgmii_act <= 1'b0;
      edge_rate <= EDGE_RST;
      loopback <= LOOP_RST;
    end else if (clk_en) begin
      ctl1 <= next_ctl1;
      rgmii_act <= next_rgmii_act;
      edge_rate <= next_edge_rate;
      loopback <= next_loopback;
    end
  end

  // interrupt flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= MASK_RST;
      int_status <= STATUS_RST;
    end else if (clk_en) begin
      int_mask <= next_int_mask;
      int_status <= next_int_status;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // settings out, all taken straight from flops
  assign cfg.rgmii = rgmii_act;
  assign cfg.skew = ctl1[CTL1_SKEW_BIT];
  assign cfg.pwr = ctl1[CTL1_PWR_BIT];
  assign cfg.tx_rev = ctl1[CTL1_REV_BIT];
  assign cfg.edge_rate = edge_rate;
  assign cfg.loopback = loopback;

  // pin follows the summary only while enabled
  assign mgmt_interrupt_pin =
    int_mask[INT_SUM_BIT] & int_status[INT_SUM_BIT];

  // level interrupt for the local processor
  assign irq = |(int_status & int_mask & CAUSE_MASK);

endmodule : pecr_regs

`default_nettype wire

/* bench/pecr_host.sv */
// pecr_host: management host model driving the register port
`default_nettype none

module pecr_host (
  input wire logic clk,
  input wire logic [pecr_pkg::DATA_W-1:0] reg_rdata,
  output logic [pecr_pkg::ADDR_W-1:0] reg_addr,
  output logic [pecr_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  import pecr_pkg::*;

  // idle bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write; released lines invert so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr

  // one-cycle read, data taken in the slot right after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd

endmodule : pecr_host

`default_nettype wire

/* bench/pecr_regs_assertions.sv */
// pecr_regs_assertions: port-level checks on the register bank
`default_nettype none

module pecr_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pecr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pecr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pecr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic soft_reset,
  input wire pecr_pkg::pecr_evt_t events,
  input wire pecr_pkg::pecr_cfg_t cfg,
  input wire logic mgmt_interrupt_pin,
  input wire logic irq
);
  import pecr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // only an event or a register write may raise an interrupt
  wire logic poke = (|events) || reg_wr;

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("stray read data");
  a_status_clear: assert property (
    reg_rd && reg_addr == OFF_STATUS && events == '0 |=> !irq)
    else $error("interrupt survived status read");
  a_pin_rise: assert property (
    $rose(mgmt_interrupt_pin) |-> irq && $past(poke))
    else $error("pin rose without pending cause");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(poke)) else $error("interrupt without cause");
  a_rgmii_hold: assert property (
    $changed(cfg.rgmii) && $past(rst_n) |-> $past(soft_reset))
    else $error("interface mode moved without soft reset");
  a_loop_write: assert property (
    reg_wr && reg_addr == OFF_CTL2 |=> cfg.loopback == $past(reg_wdata[0]))
    else $error("loopback not written");
  a_edge_write: assert property (
    reg_wr && reg_addr == OFF_CTL2 |=>
    cfg.edge_rate == $past(reg_wdata[15:13])) else $error("edge rate");
  a_rev_write: assert property (
    reg_wr && reg_addr == OFF_CTL1 |=> cfg.tx_rev == $past(reg_wdata[1])
    && cfg.skew == $past(reg_wdata[8])) else $error("control one fields");
  a_soft_loop: assert property (
    soft_reset && !reg_wr |=> !cfg.loopback) else $error("loopback kept");
endmodule : pecr_regs_chk

bind pecr_regs pecr_regs_chk i_pecr_regs_chk(.clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .soft_reset, .events, .cfg,
  .mgmt_interrupt_pin, .irq);

`default_nettype wire

/* bench/test_pecr_regs.sv */
// test_pecr_regs: self-checking bench for the control and interrupt regs
`default_nettype none

module test_pecr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import pecr_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic sticky_reset_en = 1'b1;
  // clock enable, dropped once to prove that state freezes
  logic clk_en = 1'b1;
  logic aneg_enable = 1'b1;
  logic [3:0] adv_speed_bits = 4'hf;
  logic [2:0] cable_length = 3'h0;
  pecr_evt_t events = '0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, bit_v;
  logic reg_wr, reg_rd, mgmt_interrupt_pin, irq;
  pecr_cfg_t cfg;
  int seed = 32'h22d2;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // status bit of each event, in event struct order from bit 0 up
  int pos[8] = '{1, 2, 9, 10, 11, 12, 13, 14};

  always #5 clk = ~clk;

  pecr_host i_pecr_host(.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd);
  // straps: gmii, skew on, power save off
  pecr_regs i_pecr_regs(.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .config_strap_pins(pecr_strap_t'(3'h2)),
    .soft_reset, .sticky_reset_en, .aneg_enable, .adv_speed_bits,
    .cable_length, .events, .cfg, .mgmt_interrupt_pin, .irq);

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // read a register and compare with the expected word
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] got;
    i_pecr_host.rd(a, got);
    chk(got, e);
  endtask : rc

  task automatic w(input logic [4:0] a, input logic [15:0] v);
    i_pecr_host.wr(a, v);
  endtask : w

  // one-cycle soft reset and event pulses, outputs read after the edge
  task automatic kick(input logic s, input logic [7:0] e);
    @(posedge clk);
    soft_reset <= s;
    events <= pecr_evt_t'(e);
    @(posedge clk);
    soft_reset <= 1'b0;
    events <= '0;
    #1;
  endtask : kick

  // hang guard, well above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cable_length <= 3'($random(seed));
    repeat (2) @(posedge clk);
    rc(OFF_CTL1, 16'h0100);
    rc(OFF_CTL2, {3'h6, 9'h0, cable_length, 1'b0});
    rc(OFF_MASK, 16'h0);
    rc(5'h05, 16'h0);
    // mode change waits for the soft reset
    w(OFF_CTL1, 16'hffff);
    chk(16'({cfg.rgmii, cfg.skew, cfg.tx_rev}), 16'h3);
    kick(1'b1, 8'h0);
    chk(16'(cfg.rgmii), 16'h1);
    rc(OFF_CTL1, 16'h1122);
    chk(16'(cfg.pwr), 16'h1);
    // every edge rate code, random reserved bits
    for (int i = 0; i < 8; i++) begin
      d = {3'(i), 13'($random(seed))};
      w(OFF_CTL2, d);
      rc(OFF_CTL2, {d[15:13], 9'h0, cable_length, d[0]});
    end
    w(OFF_STATUS, 16'hffff);
    rc(OFF_STATUS, 16'h0);
    // each cause alone, with pin enabled
    for (int i = 0; i < 8; i++) begin
      bit_v = 16'h1 << pos[i];
      w(OFF_MASK, 16'h8000 | bit_v);
      kick(1'b0, 8'(1 << i));
      chk(16'({mgmt_interrupt_pin, irq}), 16'h3);
      rc(OFF_STATUS, 16'h8000 | bit_v);
      chk(16'(irq), 16'h0);
    end
    // pin disabled still records the cause
    w(OFF_MASK, 16'h2000);
    kick(1'b0, 8'h40);
    chk(16'({mgmt_interrupt_pin, irq}), 16'h1);
    rc(OFF_STATUS, 16'ha000);
    // gated causes stay quiet
    w(OFF_MASK, 16'hffff);
    rc(OFF_MASK, 16'hfe06);
    @(posedge clk);
    aneg_enable <= 1'b0;
    adv_speed_bits <= 4'h7;
    kick(1'b0, 8'ha2);
    rc(OFF_STATUS, 16'h0);
    // soft reset without sticky retention
    w(OFF_CTL2, 16'h8001);
    @(posedge clk);
    sticky_reset_en <= 1'b0;
    kick(1'b1, 8'h0);
    rc(OFF_CTL1, 16'h1100);
    rc(OFF_MASK, 16'h0);
    rc(OFF_CTL2, {3'h6, 9'h0, cable_length, 1'b0});
    chk(16'(cfg.pwr), 16'h0);
    // a write while the clock enable is low must not land
    @(posedge clk);
    clk_en <= 1'b0;
    w(OFF_MASK, 16'h2000);
    @(posedge clk);
    clk_en <= 1'b1;
    rc(OFF_MASK, 16'h0);
    wrap_up;
  end

endmodule : test_pecr_regs

`default_nettype wire
